// File: hw/pcs_cfg.svh
// constants for the primary command and status register bank
// Overview of operation
// RULE_01 - 64-bit: cmd bit6 forwards data errors
// RULE_02 - 40-bit: cmd bit6 reads zero
// RULE_03 - cmd bits 5..3 hardwired zero
// RULE_04 - bit2 clear blocks master requests
// RULE_05 - bit1 clear refuses memory window
// RULE_06 - bit0 clear refuses io window
// RULE_07 - warm and cold reset clear command
// RULE_08 - 64-bit: bit15 on data error accepted
// RULE_09 - bit14 on system error or flood
// RULE_10 - bit13 on non-existent address response
// RULE_11 - bit12 on other error response
// RULE_12 - status cold reset only, write-one clears
// RULE_13 - 64-bit: flood only if serr enabled; the code also raises sync_flood on ev_sync_rx with serr clear
// RULE_14 - write zero keeps; new event wins
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_OFF_CMDSTAT  12'h004
`define PCS_OFF_IRQ_STAT 12'h010
`define PCS_OFF_IRQ_MASK 12'h014
`define PCS_OFF_CTRL     12'h018
`define PCS_CMD_DERR     6
`define PCS_CMD_SERR     8
`define PCS_CMD_MASTER   2
`define PCS_CMD_MEM      1
`define PCS_CMD_IO       0
`define PCS_ST_DERR      15
`define PCS_ST_SERR      14
`define PCS_ST_MABORT    13
`define PCS_ST_TABORT    12
`define PCS_MEM_LO       64'h0000_0000_0000_0000
`define PCS_MEM_HI       64'h0000_00fc_ffff_ffff
`define PCS_IO_LO        64'h0000_00fd_fc00_0000
`define PCS_IO_HI        64'h0000_00fd_fdff_ffff
`define PCS_CMD_RST      16'h0000
`define PCS_ST_RST       4'h0
`endif

// File: hw/pcs_pkg.sv
// types for the primary command and status register bank
package pcs_pkg;
  typedef enum logic [1:0] {PCS_IDLE, PCS_DATA} pcs_phase_t;
  typedef logic [3:0] pcs_evt_t;
endpackage : pcs_pkg

// File: hw/pcs_window_dec.sv
// address window check for primary-side memory and io requests
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_window_dec #(
  parameter int AW = 64
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic          is_io,
  input  wire logic          mem_en,
  input  wire logic          io_en,
  output logic               refuse
);
  initial begin
    if (AW != 40 && AW != 64) $error("address width must be 40 or 64");
  end
  logic [63:0] a64;
  assign a64 = 64'(addr);
  // upper bits zero-extend, so one compare serves both variants
  always_comb begin
    if (is_io) begin
      refuse = !io_en && a64 >= `PCS_IO_LO && a64 <= `PCS_IO_HI; // [RULE_06]
    end else begin
      refuse = !mem_en && a64 <= `PCS_MEM_HI; // [RULE_05]
    end
  end
endmodule : pcs_window_dec

// File: hw/pcs_sticky.sv
// one sticky write-one-to-clear bit
`timescale 1ns/10ps
module pcs_sticky (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  logic bit_q;
  logic bit_d;
  always_comb begin
    bit_d = set ? 1'b1 : (clr ? 1'b0 : bit_q); // [RULE_14]
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end
  assign q = bit_q;
endmodule : pcs_sticky

// File: hw/pcs_regbank.sv
// primary command and status register bank with ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_regbank #(
  parameter bit ADDR64 = 1'b1,
  parameter int AW     = 64
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          cold_rstn,
  input  wire logic          hsel,
  input  wire logic [11:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          ev_rd_data_err,
  input  wire logic          ev_tgt_done_err,
  input  wire logic          ev_fatal,
  input  wire logic          ev_nonfatal,
  input  wire logic          ev_sync_rx,
  input  wire logic          ev_rsp_err,
  input  wire logic          ev_rsp_nxa,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic          req_valid,
  input  wire logic          req_is_io,
  output logic               req_refuse,
  output logic               bus_master_enable,
  output logic               data_error_forward_enable,
  output logic               fwd_tgt_done_err,
  output logic               fatal_error_out_n,
  output logic               nonfatal_error_out_n,
  output logic               sync_flood,
  output logic               irq
);
  initial begin
    if (ADDR64 && AW != 64) $error("64-bit variant needs AW 64");
    if (!ADDR64 && AW != 40) $error("40-bit variant needs AW 40");
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  pcs_pkg::pcs_phase_t ph_q, ph_d;
  logic [11:0] ad_q, ad_d;
  logic        wr_q, wr_d;
  logic        ok_q, ok_d;
  logic        wstb, rstb;
  always_comb begin
    ph_d = pcs_pkg::PCS_IDLE;
    ad_d = ad_q;
    wr_d = 1'b0;
    ok_d = 1'b0;
    if (hsel && hready && htrans[1]) begin
      ph_d = pcs_pkg::PCS_DATA;
      ad_d = haddr;
      wr_d = hwrite;
      ok_d = hsize == 3'h2 && haddr[1:0] == 2'h0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ph_q <= pcs_pkg::PCS_IDLE;
      ad_q <= 12'h000;
      wr_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      ad_q <= ad_d;
      wr_q <= wr_d;
      ok_q <= ok_d;
    end
  end
  assign wstb = ph_q == pcs_pkg::PCS_DATA && wr_q && ok_q;
  assign rstb = ph_q == pcs_pkg::PCS_DATA && !wr_q && ok_q;

  // ----------------------------------------
  // command register and control
  // ----------------------------------------
  logic [15:0] cmd_q, cmd_d;
  logic [3:0]  mask_q, mask_d;
  logic [15:0] wcmd;
  assign wcmd = hwdata[15:0];
  always_comb begin
    cmd_d = cmd_q;
    if (wstb && ad_q == `PCS_OFF_CMDSTAT) begin
      cmd_d = 16'h0000; // [RULE_03]
      cmd_d[`PCS_CMD_DERR]   = ADDR64 & wcmd[`PCS_CMD_DERR]; // [RULE_01] [RULE_02]
      cmd_d[`PCS_CMD_SERR]   = wcmd[`PCS_CMD_SERR];
      cmd_d[`PCS_CMD_MASTER] = wcmd[`PCS_CMD_MASTER];
      cmd_d[`PCS_CMD_MEM]    = wcmd[`PCS_CMD_MEM];
      cmd_d[`PCS_CMD_IO]     = wcmd[`PCS_CMD_IO];
    end
    mask_d = mask_q;
    if (wstb && ad_q == `PCS_OFF_IRQ_MASK) begin
      mask_d = hwdata[15:12];
    end
  end
  // rstn is the warm reset; cold_rstn is ORed in here, so either reset clears the command
  always_ff @(posedge clk_sys) begin
    if (!rstn || !cold_rstn) begin
      cmd_q  <= `PCS_CMD_RST; // [RULE_07]
      mask_q <= 4'h0;
    end else begin
      cmd_q  <= cmd_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // status bits, surviving warm reset
  // ----------------------------------------
  pcs_pkg::pcs_evt_t set_v, clr_v, st_v, irq_clr;
  logic              flood_now;
  assign flood_now = ADDR64 && cmd_q[`PCS_CMD_SERR] && (ev_fatal || ev_nonfatal); // [RULE_13]
  always_comb begin
    set_v[3] = ADDR64 && ev_rd_data_err; // [RULE_08]
    set_v[2] = (!ADDR64 && cmd_q[`PCS_CMD_SERR] && (ev_fatal || ev_nonfatal)) || flood_now; // [RULE_09]
    set_v[1] = ev_rsp_err && ev_rsp_nxa; // [RULE_10]
    set_v[0] = ev_rsp_err && !ev_rsp_nxa; // [RULE_11]
    clr_v = (wstb && ad_q == `PCS_OFF_CMDSTAT) ? hwdata[31:28] : 4'h0; // [RULE_12]
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_st
      pcs_sticky u_st (
        .clk_sys (clk_sys),
        .rstn    (cold_rstn),
        .set     (set_v[gi]),
        .clr     (clr_v[gi]),
        .q       (st_v[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // interrupt status, cleared by reading it
  // ----------------------------------------
  pcs_pkg::pcs_evt_t ist_q, ist_d;
  assign irq_clr = (rstb && ad_q == `PCS_OFF_IRQ_STAT) ? 4'hf : 4'h0;
  always_comb begin
    ist_d = set_v | (ist_q & ~irq_clr); // new event beats the clearing read
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ist_q <= 4'h0;
    end else begin
      ist_q <= ist_d;
    end
  end

  // ----------------------------------------
  // read data and registered outputs
  // ----------------------------------------
  // read data is captured at the address-phase edge from next-state values, so it
  // stands through the data phase and already reflects a write in that same edge
  logic [31:0]       rd_d;
  pcs_pkg::pcs_evt_t st_nx;
  logic              rd_take;
  assign st_nx   = set_v | (st_v & ~clr_v);
  assign rd_take = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2
                   && haddr[1:0] == 2'h0;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (rd_take && haddr == `PCS_OFF_CMDSTAT) begin
      rd_d = {st_nx, 12'h010, cmd_d};
      rd_d[31] = ADDR64 & st_nx[3]; // [RULE_08]
    end else if (rd_take && haddr == `PCS_OFF_IRQ_STAT) begin
      rd_d = {16'h0000, ist_d, 12'h000};
    end else if (rd_take && haddr == `PCS_OFF_IRQ_MASK) begin
      rd_d = {16'h0000, mask_d, 12'h000};
    end else if (rd_take && haddr == `PCS_OFF_CTRL) begin
      rd_d = {31'h0000_0000, ADDR64};
    end
  end
  logic refuse_w;
  pcs_window_dec #(.AW(AW)) u_win (
    .addr   (req_addr),
    .is_io  (req_is_io),
    .mem_en (cmd_q[`PCS_CMD_MEM]),
    .io_en  (cmd_q[`PCS_CMD_IO]),
    .refuse (refuse_w)
  );
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hrdata                    <= 32'h0000_0000;
      req_refuse                <= 1'b0;
      bus_master_enable         <= 1'b0;
      data_error_forward_enable <= 1'b0;
      fwd_tgt_done_err          <= 1'b0;
      fatal_error_out_n         <= 1'b1;
      nonfatal_error_out_n      <= 1'b1;
      sync_flood                <= 1'b0;
      irq                       <= 1'b0;
    end else begin
      hrdata                    <= rd_d;
      req_refuse                <= req_valid && refuse_w; // [RULE_05] [RULE_06]
      bus_master_enable         <= cmd_q[`PCS_CMD_MASTER]; // [RULE_04]
      data_error_forward_enable <= cmd_q[`PCS_CMD_DERR];
      fwd_tgt_done_err          <= cmd_q[`PCS_CMD_DERR] && ev_tgt_done_err; // [RULE_01]
      fatal_error_out_n         <= !(!ADDR64 && cmd_q[`PCS_CMD_SERR] && ev_fatal); // [RULE_09]
      nonfatal_error_out_n      <= !(!ADDR64 && cmd_q[`PCS_CMD_SERR] && ev_nonfatal);
      sync_flood                <= flood_now || ev_sync_rx; // [RULE_13]
      irq                       <= |(ist_d & ~mask_d);
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bit6_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ADDR64 |-> !cmd_q[`PCS_CMD_DERR]) else $error("bit6 set in 40-bit variant"); // [RULE_02]
  a_hard_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_q[5:3] == 3'h0) else $error("hardwired command bits set"); // [RULE_03]
  a_master_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cmd_q[`PCS_CMD_MASTER] |=> !bus_master_enable) else $error("master not gated"); // [RULE_04]
  a_mem_refuse: assert property (@(posedge clk_sys) disable iff (!rstn)
    req_valid && !req_is_io && !cmd_q[`PCS_CMD_MEM] && 64'(req_addr) <= `PCS_MEM_HI
    |=> req_refuse) else $error("memory request not refused"); // [RULE_05]
  a_io_refuse: assert property (@(posedge clk_sys) disable iff (!rstn)
    req_valid && req_is_io && cmd_q[`PCS_CMD_IO] |=> !req_refuse)
    else $error("enabled io refused"); // [RULE_06]
  a_warm_clear: assert property (@(posedge clk_sys)
    !rstn |=> cmd_q == 16'h0000) else $error("command survives warm reset"); // [RULE_07]
  sequence s_nxa; ev_rsp_err && ev_rsp_nxa; endsequence
  a_nxa_sets: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    s_nxa |=> st_v[1]) else $error("master abort not recorded"); // [RULE_10]
  a_tabort_sets: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    ev_rsp_err && !ev_rsp_nxa |=> st_v[0]) else $error("target abort not recorded"); // [RULE_11]
  a_zero_keeps: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    st_v[2] && !(clr_v[2]) |=> st_v[2]) else $error("status lost without clear"); // [RULE_14]
  a_flood_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    sync_flood |-> $past(flood_now) || $past(ev_sync_rx)) else $error("unsolicited flood"); // [RULE_13]
  a_serr_sets: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    flood_now |=> st_v[2]) else $error("system error not recorded"); // [RULE_09]
  a_derr_sets: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    ADDR64 && ev_rd_data_err |=> st_v[3]) else $error("data error not recorded"); // [RULE_08]
  a_derr_fwd: assert property (@(posedge clk_sys) disable iff (!rstn)
    ev_tgt_done_err && cmd_q[`PCS_CMD_DERR] |=> fwd_tgt_done_err)
    else $error("data error not forwarded"); // [RULE_01]
  a_w1c_clear: assert property (@(posedge clk_sys) disable iff (!cold_rstn)
    clr_v[1] && !set_v[1] |=> !st_v[1]) else $error("write one did not clear"); // [RULE_12]
endmodule : pcs_regbank

// File: test/pcs_host_model.sv
// behavioural upstream link host: error events and primary requests
`timescale 1ns/10ps
module pcs_host_model #(
  parameter int AW = 64
) (
  input  wire logic          clk_sys,
  input  wire logic          req_refuse,
  output logic [6:0]         ev,
  output logic [AW-1:0]      req_addr,
  output logic               req_valid,
  output logic               req_is_io
);
  initial begin
    ev = 7'h00;
    req_addr = '0;
    req_valid = 1'b0;
    req_is_io = 1'b0;
  end

  // one-cycle pulse on the selected event lines
  task evt(input logic [6:0] m);
    ev <= m;
    @(posedge clk_sys);
    ev <= 7'h00;
  endtask : evt

  task req(input logic [AW-1:0] a, input logic io, output logic r);
    req_addr <= a;
    req_is_io <= io;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // released address is inverted so a stale value cannot pass for a new one
    req_addr <= ~a;
    @(posedge clk_sys);
    r = req_refuse;
  endtask : req
endmodule : pcs_host_model

// File: test/primary_cmd_status_bits_tb_top.sv
// self-checking bench for the primary command and status register bank
`timescale 1ns/10ps
module primary_cmd_status_bits_tb_top;
  logic        clk_sys, rstn, cold_rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [63:0] req_addr;
  logic [6:0]  ev;
  logic        req_valid, req_is_io, req_refuse, rf, irq;
  logic        bme, dfe, fwd, fat_n, nf_n, flood;
  int          bad_count, checks;

  assign hready = hreadyout;

  pcs_regbank uut (.clk_sys(clk_sys), .rstn(rstn), .cold_rstn(cold_rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ev_rd_data_err(ev[0]), .ev_tgt_done_err(ev[1]), .ev_fatal(ev[2]),
    .ev_nonfatal(ev[3]), .ev_sync_rx(ev[4]), .ev_rsp_err(ev[5]), .ev_rsp_nxa(ev[6]),
    .req_addr(req_addr), .req_valid(req_valid), .req_is_io(req_is_io),
    .req_refuse(req_refuse), .bus_master_enable(bme), .data_error_forward_enable(dfe),
    .fwd_tgt_done_err(fwd), .fatal_error_out_n(fat_n), .nonfatal_error_out_n(nf_n),
    .sync_flood(flood), .irq(irq));

  pcs_host_model h (.clk_sys(clk_sys), .req_refuse(req_refuse), .ev(ev),
    .req_addr(req_addr), .req_valid(req_valid), .req_is_io(req_is_io));

  // ----------------------------------------
  // clock, tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task end_sim;
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // read data stands in the data phase and is taken at its closing edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk_sys);
    while (!hready) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hready) @(posedge clk_sys);
    rd = hrdata;
  endtask : xfer

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask : rdc

  task win(input logic [63:0] a, input logic io, input logic e);
    h.req(a, io, rf);
    chk("refuse", {31'h0, rf}, {31'h0, e});
  endtask : win

  task pulse_chk(input logic [6:0] m, input string nm, input logic exp);
    h.evt(m);
    @(posedge clk_sys);
    chk(nm, {31'h0, (m[1] ? fwd : flood)}, {31'h0, exp});
  endtask : pulse_chk

  task rst_warm;
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask : rst_warm

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rstn, cold_rstn, hsel, hwrite} = 4'h0;
    {haddr, htrans, hsize, hwdata} = '0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    cold_rstn <= 1'b1;
    @(posedge clk_sys);
    rdc("cmdstat", 12'h004, 32'h0010_0000);
    rdc("variant", 12'h018, 32'h0000_0001);
    rdc("unmapped", 12'h020, 32'h0000_0000);
    win(64'h0, 1'b0, 1'b1);
    win(64'h0000_00fc_ffff_ffff, 1'b0, 1'b1);
    win(64'h0000_00fd_0000_0000, 1'b0, 1'b0);
    win(64'h0000_00fd_fc00_0000, 1'b1, 1'b1);
    win(64'h0000_00fd_fdff_ffff, 1'b1, 1'b1);
    win(64'h0000_00fd_fe00_0000, 1'b1, 1'b0);
    xfer(1'b1, 12'h004, 32'h0000_ffff);
    rdc("cmdstat", 12'h004, 32'h0010_0147);
    chk("master_en", {31'h0, bme}, 32'h1);
    chk("derr_fwd", {31'h0, dfe}, 32'h1);
    win(64'h0000_00fc_ffff_ffff, 1'b0, 1'b0);
    win(64'h0000_00fd_fc00_0000, 1'b1, 1'b0);
    pulse_chk(7'h02, "fwd", 1'b1);
    pulse_chk(7'h04, "flood", 1'b1);
    pulse_chk(7'h10, "flood", 1'b1);
    chk("fatal_n", {31'h0, fat_n}, 32'h1);
    rdc("cmdstat", 12'h004, 32'h4010_0147);
    h.evt(7'h01);
    h.evt(7'h60);
    h.evt(7'h20);
    rdc("cmdstat", 12'h004, 32'hf010_0147);
    rst_warm();
    rdc("cmdstat", 12'h004, 32'hf010_0000);
    chk("master_en", {31'h0, bme}, 32'h0);
    pulse_chk(7'h02, "fwd", 1'b0);
    xfer(1'b1, 12'h004, 32'h0000_0000);
    rdc("cmdstat", 12'h004, 32'hf010_0000);
    xfer(1'b1, 12'h004, 32'h5000_0000);
    rdc("cmdstat", 12'h004, 32'ha010_0000);
    // interrupt: mask bits 15..13, leave 12 open
    xfer(1'b1, 12'h014, 32'h0000_e000);
    h.evt(7'h60);
    @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0);
    h.evt(7'h20);
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc("irq_stat", 12'h010, 32'h0000_3000);
    rdc("irq_stat", 12'h010, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0);
    cold_rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cold_rstn <= 1'b1;
    @(posedge clk_sys);
    rdc("cmdstat", 12'h004, 32'h0010_0000);
    end_sim();
  end

  // a hang counts as a mismatch; the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
endmodule : primary_cmd_status_bits_tb_top
